// file: sdi_pkg.sv
package sdi_pkg;

  // array geometry: four banks of 8192 rows by 512 columns, 16 bits each
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int COL_W = 9;
  localparam int DQ_W = 16;
  localparam int LANES = 2;
  localparam int BANKS = 4;
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;

  // command code on {ras_b, cas_b, we_b}
  localparam logic [2:0] CMD_MRS = 3'h0;
  localparam logic [2:0] CMD_REF = 3'h1;
  localparam logic [2:0] CMD_PRE = 3'h2;
  localparam logic [2:0] CMD_ACT = 3'h3;
  localparam logic [2:0] CMD_WR = 3'h4;
  localparam logic [2:0] CMD_RD = 3'h5;
  localparam logic [2:0] CMD_BST = 3'h6;

  // bank address selecting the base or the extended mode register
  localparam logic [1:0] BA_MODE = 2'h0;
  localparam logic [1:0] BA_EXT = 2'h2;

  // base mode register fields
  localparam int BL_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int SW_BIT = 9;
  localparam int AP_BIT = 10;
  localparam logic [2:0] BL_1 = 3'h0;
  localparam logic [2:0] BL_2 = 3'h1;
  localparam logic [2:0] BL_4 = 3'h2;
  localparam logic [2:0] BL_8 = 3'h3;
  localparam logic [2:0] BL_FP = 3'h7;
  localparam logic [2:0] CL_3 = 3'h3;

  // extended mode register fields: retained array part, self refresh period
  localparam int PASR_LSB = 0;
  localparam int TCSR_LSB = 3;

  localparam logic [ROW_W-1:0] MODE_RST = 13'h0000;
  localparam logic [COL_W-1:0] COL_ZERO = 9'h000;
  localparam logic [COL_W-1:0] SPAN_1 = 9'h000;
  localparam logic [COL_W-1:0] SPAN_2 = 9'h001;
  localparam logic [COL_W-1:0] SPAN_4 = 9'h003;
  localparam logic [COL_W-1:0] SPAN_8 = 9'h007;
  localparam logic [COL_W-1:0] SPAN_FP = 9'h1ff;

  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic cke;
    logic [BANK_W-1:0] ba;
    logic [ROW_W-1:0] addr;
  } sdi_cmd_t;

  typedef struct packed {
    logic upper_byte_mask;
    logic lower_byte_mask;
  } sdi_mask_t;

  typedef enum logic [2:0] {
    PS_RUN = 3'h1,
    PS_SELF = 3'h2,
    PS_DPD = 3'h4
  } sdi_pstate_t;

endpackage

// file: sdi_array.sv
`timescale 1ns/10ps
module sdi_array (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // access port
  input wire logic [sdi_pkg::MEM_AW-1:0] addr_i,
  input wire logic [sdi_pkg::LANES-1:0] wr_lane_i,
  input wire logic [sdi_pkg::DQ_W-1:0] wdata_i,
  input wire logic rd_i,
  // registered read data, one cycle after rd_i
  output logic [sdi_pkg::DQ_W-1:0] rdata_o
);

  localparam int LANE_W = sdi_pkg::DQ_W / sdi_pkg::LANES;

  // one array per lane, so each lane's write enable owns its own storage
  for (genvar g = 0; g < sdi_pkg::LANES; g++)
  begin : g_lane
    logic [LANE_W-1:0] mem [0:(1<<sdi_pkg::MEM_AW)-1];
    logic [LANE_W-1:0] rd_q;

    // a lane is written only when its write enable is high
    always_ff @(posedge clk_i)
    begin
      if (wr_lane_i[g])
        mem[addr_i] <= wdata_i[g*LANE_W +: LANE_W];
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
      if (!rst_b_i)
        rd_q <= '0;
      else if (rd_i)
        rd_q <= mem[addr_i];
    end

    assign rdata_o[g*LANE_W +: LANE_W] = rd_q;
  end

endmodule // sdi_array

// file: sdi_core.sv
`timescale 1ns/10ps
module sdi_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // command pins
  input wire sdi_pkg::sdi_cmd_t cmd_i,
  // byte masks
  input wire sdi_pkg::sdi_mask_t mask_i,
  // data pins, split for the two-way bus
  input wire logic [sdi_pkg::DQ_W-1:0] dq_i,
  output logic [sdi_pkg::DQ_W-1:0] dq_o,
  output logic [sdi_pkg::LANES-1:0] dq_oe_o,
  // status
  output logic mode_valid_o,
  output logic self_refresh_o,
  output logic deep_power_down_o,
  output logic [2:0] pasr_o,
  output logic [1:0] tcsr_o
);

  typedef struct packed {
    sdi_pkg::sdi_pstate_t ps;
    logic cke;
    logic mode_valid;
    logic [sdi_pkg::ROW_W-1:0] mode;
    logic [sdi_pkg::ROW_W-1:0] ext;
    logic [sdi_pkg::BANKS-1:0] open;
    logic [sdi_pkg::BANKS-1:0][sdi_pkg::ROW_W-1:0] row;
    logic b_act;
    logic b_wr;
    logic b_ap;
    logic b_il;
    logic [sdi_pkg::BANK_W-1:0] b_bank;
    logic [sdi_pkg::COL_W-1:0] b_start;
    logic [sdi_pkg::COL_W-1:0] b_span;
    logic [sdi_pkg::COL_W-1:0] b_idx;
    logic rv1;
    logic rv2;
    logic [sdi_pkg::DQ_W-1:0] rs2;
    logic [sdi_pkg::LANES-1:0] mask_d1;
    logic [sdi_pkg::DQ_W-1:0] dq;
    logic [sdi_pkg::LANES-1:0] oe;
  } sdi_state_t;

  localparam sdi_state_t ST_RST = '{ps: sdi_pkg::PS_RUN, default: '0};

  sdi_state_t s_q, s_d;

  logic [sdi_pkg::DQ_W-1:0] rdata;
  logic [sdi_pkg::MEM_AW-1:0] m_addr;
  logic [sdi_pkg::LANES-1:0] m_wr;
  logic m_rd;

  // wrap mask of a burst: which column bits advance inside the block
  function automatic logic [sdi_pkg::COL_W-1:0] span_of(input logic [2:0] bl);
    unique case (bl)
      sdi_pkg::BL_2: span_of = sdi_pkg::SPAN_2;
      sdi_pkg::BL_4: span_of = sdi_pkg::SPAN_4;
      sdi_pkg::BL_8: span_of = sdi_pkg::SPAN_8;
      sdi_pkg::BL_FP: span_of = sdi_pkg::SPAN_FP;
      default: span_of = sdi_pkg::SPAN_1;
    endcase
  endfunction

  // column of beat idx, sequential or interleaved, wrapping in the block
  function automatic logic [sdi_pkg::COL_W-1:0] beat_col(
    input logic [sdi_pkg::COL_W-1:0] start,
    input logic [sdi_pkg::COL_W-1:0] span,
    input logic [sdi_pkg::COL_W-1:0] idx,
    input logic il
  );
    logic [sdi_pkg::COL_W-1:0] low;
    low = il ? (start ^ idx) : sdi_pkg::COL_W'(start + idx);
    beat_col = (start & ~span) | (low & span);
  endfunction

  logic [2:0] op;
  logic live;
  logic ck_ok;
  logic [sdi_pkg::COL_W-1:0] cur_col;
  logic [sdi_pkg::COL_W-1:0] cur_span;
  logic [sdi_pkg::COL_W-1:0] cur_idx;
  logic [sdi_pkg::BANK_W-1:0] cur_bank;
  logic cur_act;
  logic cur_wr;
  logic cur_ap;
  logic cur_il;
  logic new_acc;

  always_comb
  begin
    s_d = s_q;
    op = {cmd_i.ras_b, cmd_i.cas_b, cmd_i.we_b};
    ck_ok = cmd_i.cke && s_q.cke;
    live = ck_ok && !cmd_i.cs_b && (s_q.ps == sdi_pkg::PS_RUN);
    s_d.cke = cmd_i.cke;

    // access is taken only to an open bank once the mode is known
    new_acc = live && (op == sdi_pkg::CMD_RD || op == sdi_pkg::CMD_WR)
      && s_q.open[cmd_i.ba] && s_q.mode_valid;
    if (new_acc)
    begin
      cur_act = 1'b1;
      cur_wr = (op == sdi_pkg::CMD_WR);
      cur_ap = cmd_i.addr[sdi_pkg::AP_BIT];
      cur_il = s_q.mode[sdi_pkg::BT_BIT];
      cur_bank = cmd_i.ba;
      cur_col = cmd_i.addr[sdi_pkg::COL_W-1:0];
      cur_idx = sdi_pkg::COL_ZERO;
      if (cur_wr && s_q.mode[sdi_pkg::SW_BIT])
        cur_span = sdi_pkg::SPAN_1;
      else
        cur_span = span_of(s_q.mode[sdi_pkg::BL_LSB +: 3]);
    end
    else
    begin
      cur_act = s_q.b_act && !(live && op == sdi_pkg::CMD_BST);
      cur_wr = s_q.b_wr;
      cur_ap = s_q.b_ap;
      cur_il = s_q.b_il;
      cur_bank = s_q.b_bank;
      cur_col = s_q.b_start;
      cur_idx = s_q.b_idx;
      cur_span = s_q.b_span;
    end

    m_addr = {cur_bank, s_q.row[cur_bank], beat_col(cur_col, cur_span, cur_idx, cur_il)};
    m_rd = cur_act && !cur_wr;
    m_wr[1] = cur_act && cur_wr && !mask_i.upper_byte_mask;
    m_wr[0] = cur_act && cur_wr && !mask_i.lower_byte_mask;

    s_d.b_act = cur_act && (cur_idx != cur_span);
    s_d.b_wr = cur_wr;
    s_d.b_ap = cur_ap;
    s_d.b_il = cur_il;
    s_d.b_bank = cur_bank;
    s_d.b_start = cur_col;
    s_d.b_span = cur_span;
    s_d.b_idx = sdi_pkg::COL_W'(cur_idx + 1'b1);
    if (cur_act && cur_ap && (cur_idx == cur_span))
      s_d.open[cur_bank] = 1'b0;

    if (live)
    begin
      unique case (op)
        sdi_pkg::CMD_ACT:
        begin
          s_d.open[cmd_i.ba] = 1'b1;
          s_d.row[cmd_i.ba] = cmd_i.addr;
        end
        sdi_pkg::CMD_PRE:
        begin
          if (cmd_i.addr[sdi_pkg::AP_BIT])
            s_d.open = '0;
          else
            s_d.open[cmd_i.ba] = 1'b0;
        end
        sdi_pkg::CMD_MRS:
        begin
          if (cmd_i.ba == sdi_pkg::BA_MODE)
          begin
            s_d.mode = cmd_i.addr;
            s_d.mode_valid = 1'b1;
          end
          else if (cmd_i.ba == sdi_pkg::BA_EXT)
            s_d.ext = cmd_i.addr;
        end
        default:
        begin
        end
      endcase
    end

    // power states entered when clock enable falls with the command
    unique case (s_q.ps)
      sdi_pkg::PS_RUN:
      begin
        if (s_q.cke && !cmd_i.cke && !cmd_i.cs_b && op == sdi_pkg::CMD_REF)
          s_d.ps = sdi_pkg::PS_SELF;
        else if (s_q.cke && !cmd_i.cke && !cmd_i.cs_b && op == sdi_pkg::CMD_BST)
          s_d.ps = sdi_pkg::PS_DPD;
      end
      sdi_pkg::PS_SELF:
      begin
        if (cmd_i.cke)
          s_d.ps = sdi_pkg::PS_RUN;
      end
      sdi_pkg::PS_DPD:
      begin
        if (cmd_i.cke)
        begin
          s_d.ps = sdi_pkg::PS_RUN;
          s_d.mode_valid = 1'b0;
          s_d.open = '0;
        end
      end
      default:
        s_d.ps = sdi_pkg::PS_RUN;
    endcase
    if (s_q.ps != sdi_pkg::PS_RUN)
      s_d.b_act = 1'b0;

    // read data pipe: array output one cycle after the beat
    s_d.rv1 = m_rd;
    s_d.rv2 = s_q.rv1;
    s_d.rs2 = rdata;
    if (s_q.mode[sdi_pkg::CL_LSB +: 3] == sdi_pkg::CL_3)
    begin
      s_d.dq = s_q.rs2;
      s_d.oe[1] = s_q.rv2 && !s_q.mask_d1[1];
      s_d.oe[0] = s_q.rv2 && !s_q.mask_d1[0];
    end
    else
    begin
      s_d.dq = rdata;
      s_d.oe[1] = s_q.rv1 && !s_q.mask_d1[1];
      s_d.oe[0] = s_q.rv1 && !s_q.mask_d1[0];
    end
    s_d.mask_d1 = {mask_i.upper_byte_mask, mask_i.lower_byte_mask};
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      s_q <= ST_RST;
    else
      s_q <= s_d;
  end

  sdi_array u_array (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .addr_i(m_addr),
    .wr_lane_i(m_wr),
    .wdata_i(dq_i),
    .rd_i(m_rd),
    .rdata_o(rdata)
  );

  assign dq_o = s_q.dq;
  assign dq_oe_o = s_q.oe;
  assign mode_valid_o = s_q.mode_valid;
  assign self_refresh_o = (s_q.ps == sdi_pkg::PS_SELF);
  assign deep_power_down_o = (s_q.ps == sdi_pkg::PS_DPD);
  assign pasr_o = s_q.ext[sdi_pkg::PASR_LSB +: 3];
  assign tcsr_o = s_q.ext[sdi_pkg::TCSR_LSB +: 2];

endmodule // sdi_core

// file: sdi_host.sv
`timescale 1ns/10ps
module sdi_host #(
  parameter logic [12:0] MODE = 13'h0021,
  parameter int PAUSE = 20
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pins toward the device
  output sdi_pkg::sdi_cmd_t cmd_o,
  output sdi_pkg::sdi_mask_t mask_o,
  // client side
  output logic ready_o
);
  // c is {cke, ras_b, cas_b, we_b}
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
    input logic [1:0] m);
    @(negedge clk_i);
    cmd_o = {1'b0, c[2:0], c[3], b, a};
    mask_o = m;
  endtask
  initial
  begin
    cmd_o = {1'b0, 3'h7, 1'b1, 2'h0, 13'h0000};
    mask_o = 2'h3;
    ready_o = 1'b0;
    @(posedge rst_b_i);
    repeat (PAUSE) issue(4'hf, 2'h0, 13'h0000, 2'h3);
    issue(4'ha, 2'h0, 13'h0400, 2'h3);
    repeat (8) issue(4'h9, 2'h0, 13'h0000, 2'h3);
    issue(4'h8, 2'h0, MODE, 2'h3);
    issue(4'hf, 2'h0, 13'h0000, 2'h0);
    ready_o = 1'b1;
  end
endmodule  // sdi_host

// file: sdi_core_props.sv
`timescale 1ns/10ps
module sdi_core_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // inputs
  input wire sdi_pkg::sdi_cmd_t cmd_i,
  input wire sdi_pkg::sdi_mask_t mask_i,
  // outputs
  input wire logic [sdi_pkg::LANES-1:0] dq_oe_o,
  input wire logic mode_valid_o,
  input wire logic self_refresh_o,
  input wire logic deep_power_down_o,
  input wire logic [2:0] pasr_o,
  input wire logic [1:0] tcsr_o
);
  logic cke_q;
  logic run_q;
  wire logic [2:0] code = {cmd_i.ras_b, cmd_i.cas_b, cmd_i.we_b};
  wire logic up = !self_refresh_o && !deep_power_down_o && run_q && !cmd_i.cs_b && cke_q;
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cke_q <= 1'b0;
      run_q <= 1'b0;
    end
    else
    begin
      cke_q <= cmd_i.cke;
      run_q <= 1'b1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_mrs(logic [1:0] b);
    up && cmd_i.cke && code == 3'h0 && cmd_i.ba == b;
  endsequence
  sequence s_down(logic [2:0] c);
    up && !cmd_i.cke && code == c;
  endsequence
  reset_clear_a: assert property (
    $rose(rst_b_i) |-> !mode_valid_o && dq_oe_o == 2'h0) else $error("not clear");
  mode_set_a: assert property (
    s_mrs(2'h0) |=> mode_valid_o) else $error("mode set lost");
  mode_cause_a: assert property (
    $rose(mode_valid_o) |-> $past(up && cmd_i.cke && code == 3'h0 && cmd_i.ba == 2'h0))
    else $error("mode valid uncaused");
  upper_mask_a: assert property (
    dq_oe_o[1] |-> !$past(mask_i.upper_byte_mask, 2)) else $error("upper lane unmasked");
  lower_mask_a: assert property (
    dq_oe_o[0] |-> !$past(mask_i.lower_byte_mask, 2)) else $error("lower lane unmasked");
  self_ref_a: assert property (
    s_down(3'h1) |=> self_refresh_o) else $error("no self refresh");
  deep_down_a: assert property (
    s_down(3'h6) |=> deep_power_down_o) else $error("no deep power down");
  ext_mode_a: assert property (
    s_mrs(2'h2) |=> pasr_o == $past(cmd_i.addr[2:0]) && tcsr_o == $past(cmd_i.addr[4:3]))
    else $error("extended mode wrong");
endmodule  // sdi_core_props
bind sdi_core sdi_core_props i_sdi_core_props (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .cmd_i(cmd_i), .mask_i(mask_i), .dq_oe_o(dq_oe_o), .mode_valid_o(mode_valid_o),
  .self_refresh_o(self_refresh_o), .deep_power_down_o(deep_power_down_o),
  .pasr_o(pasr_o), .tcsr_o(tcsr_o));

// file: sdi_core_tb.sv
`timescale 1ns/10ps
module sdi_core_tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [15:0] hdq = 16'h0000;
  int bad_count = 0;
  int compares = 0;
  sdi_pkg::sdi_cmd_t cmd;
  sdi_pkg::sdi_mask_t mask;
  logic rdy;
  logic [15:0] dq_i;
  logic [15:0] dq_o;
  logic [1:0] oe;
  logic mv;
  logic sr;
  logic dpd;
  logic [2:0] pasr;
  logic [1:0] tcsr;
  always #10 clk_i = ~clk_i;
  assign dq_i = {oe[1] ? dq_o[15:8] : hdq[15:8], oe[0] ? dq_o[7:0] : hdq[7:0]};
  sdi_host i_sdi_host (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_o(cmd), .mask_o(mask),
    .ready_o(rdy));
  sdi_core i_sdi_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .cmd_i(cmd), .mask_i(mask),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe_o(oe), .mode_valid_o(mv), .self_refresh_o(sr),
    .deep_power_down_o(dpd), .pasr_o(pasr), .tcsr_o(tcsr));
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a,
    input logic [1:0] m);
    i_sdi_host.issue(c, b, a, m);
  endtask
  task automatic wr(input logic [1:0] b, input logic [12:0] c, input logic [15:0] d0, d1,
    input logic [1:0] m0, m1);
    go(4'hc, b, c, m0);
    hdq = d0;
    go(4'hf, b, 13'h0000, m1);
    hdq = d1;
    go(4'hf, b, 13'h0000, 2'h0);
    hdq = ~d1;
  endtask
  task automatic rd(input logic [1:0] b, input logic [12:0] c, input logic [1:0] m0, m1,
    input logic [15:0] e0, e1);
    logic [15:0] k;
    go(4'hd, b, c, m0);
    go(4'hf, b, 13'h0000, m1);
    go(4'hf, b, 13'h0000, 2'h0);
    k = {{8{~m0[1]}}, {8{~m0[0]}}};
    check("oe beat0", {14'h0000, oe}, {14'h0000, ~m0});
    check("data beat0", dq_o & k, e0 & k);
    go(4'hf, b, 13'h0000, 2'h0);
    k = {{8{~m1[1]}}, {8{~m1[0]}}};
    check("oe beat1", {14'h0000, oe}, {14'h0000, ~m1});
    check("data beat1", dq_o & k, e1 & k);
    go(4'hf, b, 13'h0000, 2'h0);
    check("oe idle", {14'h0000, oe}, 16'h0000);
  endtask
  task automatic t_masks();
    go(4'hb, 2'h1, 13'h0005, 2'h0);
    wr(2'h1, 13'h0004, 16'h1111, 16'h2222, 2'h0, 2'h0);
    wr(2'h1, 13'h0004, 16'haaaa, 16'hbbbb, 2'h1, 2'h2);
    rd(2'h1, 13'h0004, 2'h0, 2'h0, 16'haa11, 16'h22bb);
    rd(2'h1, 13'h0004, 2'h2, 2'h1, 16'haa11, 16'h22bb);
  endtask
  task automatic t_banks();
    go(4'hb, 2'h0, 13'h1fff, 2'h0);
    go(4'hb, 2'h3, 13'h1fff, 2'h0);
    wr(2'h0, 13'h01fe, 16'h0f0f, 16'h1e1e, 2'h0, 2'h0);
    wr(2'h3, 13'h01fe, 16'hf0f0, 16'he1e1, 2'h0, 2'h0);
    rd(2'h0, 13'h01fe, 2'h0, 2'h0, 16'h0f0f, 16'h1e1e);
    rd(2'h3, 13'h01fe, 2'h0, 2'h0, 16'hf0f0, 16'he1e1);
  endtask
  task automatic t_power();
    go(4'ha, 2'h0, 13'h0400, 2'h0);
    go(4'h8, 2'h2, 13'h001d, 2'h0);
    go(4'hf, 2'h0, 13'h0000, 2'h0);
    check("pasr tcsr", {11'h000, tcsr, pasr}, 16'h001d);
    go(4'h1, 2'h0, 13'h0000, 2'h0);
    go(4'h7, 2'h0, 13'h0000, 2'h0);
    check("self refresh", {15'h0000, sr}, 16'h0001);
    repeat (3) go(4'hf, 2'h0, 13'h0000, 2'h0);
    check("self exit", {15'h0000, sr}, 16'h0000);
    go(4'h6, 2'h0, 13'h0000, 2'h0);
    go(4'h7, 2'h0, 13'h0000, 2'h0);
    check("deep down", {15'h0000, dpd}, 16'h0001);
    repeat (3) go(4'hf, 2'h0, 13'h0000, 2'h0);
    check("mode after dpd", {14'h0000, dpd, mv}, 16'h0000);
    go(4'hb, 2'h1, 13'h0005, 2'h0);
    go(4'hd, 2'h1, 13'h0004, 2'h0);
    repeat (4)
    begin
      go(4'hf, 2'h0, 13'h0000, 2'h0);
      check("oe unset mode", {14'h0000, oe}, 16'h0000);
    end
  endtask
  // burst of four, interleaved, read latency three
  task automatic t_cl3();
    go(4'ha, 2'h0, 13'h0400, 2'h0);
    go(4'h8, 2'h0, 13'h003a, 2'h0);
    go(4'hb, 2'h2, 13'h0007, 2'h0);
    go(4'hc, 2'h2, 13'h0001, 2'h0);
    hdq = 16'ha151;
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    hdq = 16'ha050;
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    hdq = 16'ha353;
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    hdq = 16'ha252;
    go(4'hd, 2'h2, 13'h0002, 2'h0);
    go(4'hf, 2'h2, 13'h0000, 2'h2);
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    check("cl3 oe beat0", {14'h0000, oe}, 16'h0001);
    check("cl3 data beat0", dq_o & 16'h00ff, 16'h0052);
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    check("cl3 oe beat1", {14'h0000, oe}, 16'h0003);
    check("cl3 data beat1", dq_o, 16'ha353);
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    check("cl3 data beat2", dq_o, 16'ha050);
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    check("cl3 data beat3", dq_o, 16'ha151);
    go(4'hf, 2'h2, 13'h0000, 2'h0);
    check("cl3 oe idle", {14'h0000, oe}, 16'h0000);
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    check("outputs at reset", {6'h00, pasr, tcsr, dpd, sr, mv, oe}, 16'h0000);
    check("data at reset", dq_o, 16'h0000);
    for (int i = 0; i < 100 && rdy !== 1'b1; i++)
      @(negedge clk_i);
    check("mode set", {15'h0000, mv}, 16'h0001);
    t_masks();
    t_banks();
    t_power();
    t_cl3();
    summarize();
  end
  initial
  begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    summarize();
  end
endmodule  // sdi_core_tb
